/* File: verilog/tsab_pkg.sv */
package tsab_pkg;

  // --------------------------------------------------------------
  // Bus addressing
  // --------------------------------------------------------------
  localparam logic [3:0] ADDR_UPPER = 4'h9;
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;

  // --------------------------------------------------------------
  // Pointer values
  // --------------------------------------------------------------
  localparam logic [1:0] PTR_TEMPERATURE = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_HYSTERESIS = 2'h2;
  localparam logic [1:0] PTR_OVERTEMP = 2'h3;

  // --------------------------------------------------------------
  // Configuration bit positions
  // --------------------------------------------------------------
  localparam int CFG_SHUTDOWN_BIT = 0;
  localparam int CFG_INTERRUPT_MODE_SELECT_BIT = 1;
  localparam int CFG_POLARITY_BIT = 2;
  localparam int CFG_ALERT_FUNCTION_ENABLE_BIT = 7;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] HYSTERESIS_RESET = 16'h4B00;
  localparam logic [15:0] OVERTEMP_RESET = 16'h5000;
  localparam logic [1:0] POINTER_RESET = 2'h0;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int TIMEOUT_MIN_MS = 75;
  localparam int TIMEOUT_MAX_MS = 325;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MIN_MS * CLK_FREQ_KHZ;

  // --------------------------------------------------------------
  // Serial engine states
  // --------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR_BYTE = 7'h08,
    ST_WR_ACK = 7'h10,
    ST_RD_BYTE = 7'h20,
    ST_RD_ACK = 7'h40
  } tsab_state_type;

endpackage

/* File: verilog/tsab_sync.sv */
`timescale 1ns/1ps
module tsab_sync #(
  parameter int WIDTH = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // --------------------------------------------------------------
  // Two-stage synchroniser
  // --------------------------------------------------------------
  logic [WIDTH-1:0] stage_one;

  generate
    if (WIDTH < 1) begin : g_width_check
      $error("tsab_sync WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage_one <= '1;
      sync_out <= '1;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

/* File: verilog/tsab_top.sv */
`timescale 1ns/1ps
// Function
// - Pointer-only write changes pointer, nothing else
// - Config write takes exactly one data byte
// - Limit writes take two data bytes
// - Surplus write bytes discarded, registers untouched
// - Reads return one or two bytes, MSB first
// - Pointer persists, never auto-increments
// - Power-up default is comparator mode
// - Assert when temperature exceeds overtemp limit
// - Comparator deasserts below hysteresis limit
// - Comparator shutdown keeps output state
// - Interrupt mode: any register read deasserts
// - Interrupt events alternate high then low
// - Alert response read clears output
// - Interrupt mode shutdown clears output
// - Alert function needs enable and interrupt mode
// - Output is open-drain, pulls low only
// - Alert response address answered with own address
// - Response LSB tells which limit tripped
// - Lowest address wins alert response arbitration
// - Release alert after answering response
// - Address is 1001 plus select pins
// - Config bit one selects interrupt mode
// - Data line idle timeout releases bus
module tsab_top #(
  parameter int TIMEOUT_CYCLES = tsab_pkg::TIMEOUT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin_2,
  input wire logic address_select_pin_1,
  input wire logic address_select_pin_0,
  input wire logic [15:0] temperature,
  output logic overtemp_alert_output_out,
  output logic overtemp_alert_output_oe,
  output logic overtemp_indicator,
  output logic [7:0] config_value,
  output logic [15:0] hysteresis_limit,
  output logic [15:0] overtemp_limit
);

  // --------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------
  if (TIMEOUT_CYCLES < 1) begin : g_timeout_check
    $error("TIMEOUT_CYCLES must be at least 1");
  end

  // --------------------------------------------------------------
  // Pin synchronisation and edge detection
  // --------------------------------------------------------------
  logic [4:0] pins_sync;
  logic scl_prev, sda_prev;
  tsab_sync #(.WIDTH(5)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({scl_in, sda_in, address_select_pin_2, address_select_pin_1, address_select_pin_0}),
    .sync_out(pins_sync)
  );
  wire scl_s = pins_sync[4];
  wire sda_s = pins_sync[3];
  wire scl_rise = scl_s & ~scl_prev;
  wire scl_fall = ~scl_s & scl_prev;
  wire start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  wire stop_det = scl_s & scl_prev & ~sda_prev & sda_s;
  wire [6:0] own_addr = {tsab_pkg::ADDR_UPPER, pins_sync[2:0]};

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  tsab_pkg::tsab_state_type state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift, tx, next_tx, stash;
  logic [1:0] byte_idx, next_byte_idx, pointer;
  logic [31:0] idle_cnt;
  logic next_sda_oe, rw, next_rw, is_ara, next_is_ara, rd_more, next_rd_more;
  logic wr_strobe, rd_addr_ack, ara_done, armed_high, limit_flag, prev_int_mode, prev_shutdown;

  // --------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------
  wire int_mode = config_value[tsab_pkg::CFG_INTERRUPT_MODE_SELECT_BIT];
  wire shutdown = config_value[tsab_pkg::CFG_SHUTDOWN_BIT];
  wire active_high = config_value[tsab_pkg::CFG_POLARITY_BIT];
  wire alert_mode = int_mode & config_value[tsab_pkg::CFG_ALERT_FUNCTION_ENABLE_BIT];
  wire ara_ready = alert_mode & overtemp_indicator;
  wire timed_out = (state != tsab_pkg::ST_IDLE) && (idle_cnt >= 32'(TIMEOUT_CYCLES - 1));
  wire addr_hit = (shift[7:1] == own_addr);
  wire ara_hit = (shift[7:1] == tsab_pkg::ALERT_RESPONSE_ADDR) & shift[0] & ara_ready;
  wire is_limit_ptr = (pointer == tsab_pkg::PTR_HYSTERESIS) || (pointer == tsab_pkg::PTR_OVERTEMP);
  wire [15:0] rd_word = (pointer == tsab_pkg::PTR_TEMPERATURE) ? temperature :
                        (pointer == tsab_pkg::PTR_HYSTERESIS) ? hysteresis_limit :
                        (pointer == tsab_pkg::PTR_OVERTEMP) ? overtemp_limit :
                        {config_value, config_value};
  wire [7:0] ara_byte = {own_addr, limit_flag};
  wire [7:0] first_byte = is_ara ? ara_byte : rd_word[15:8];
  wire [7:0] later_byte = (pointer == tsab_pkg::PTR_CONFIG) ? config_value : rd_word[7:0];
  wire above = $signed(temperature) > $signed(overtemp_limit);
  wire below = $signed(temperature) < $signed(hysteresis_limit);
  wire shutdown_entry = shutdown & ~prev_shutdown;
  wire int_clear = rd_addr_ack | (ara_done & alert_mode) | shutdown_entry;
  wire int_set = ~shutdown & ~overtemp_indicator & (armed_high ? above : below);
  wire pin_level = active_high ? overtemp_indicator : ~overtemp_indicator;

  // --------------------------------------------------------------
  // Serial engine next state
  // --------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_tx = tx;
    next_byte_idx = byte_idx;
    next_sda_oe = sda_oe;
    next_rw = rw;
    next_is_ara = is_ara;
    next_rd_more = rd_more;
    wr_strobe = 1'b0;
    rd_addr_ack = 1'b0;
    ara_done = 1'b0;
    if (stop_det || timed_out) begin
      next_state = tsab_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_det) begin
      next_state = tsab_pkg::ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
      next_is_ara = 1'b0;
    end else begin
      case (state)
        tsab_pkg::ST_ADDR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_state = tsab_pkg::ST_IDLE;
            if (addr_hit || ara_hit) begin
              next_state = tsab_pkg::ST_ADDR_ACK;
              next_sda_oe = 1'b1;
              next_rw = shift[0];
              next_is_ara = ara_hit & ~addr_hit;
              next_byte_idx = 2'h0;
              rd_addr_ack = shift[0] & addr_hit;
            end
          end
        end
        tsab_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (rw) begin
              next_state = tsab_pkg::ST_RD_BYTE;
              next_tx = first_byte;
              next_sda_oe = ~first_byte[7];
            end else begin
              next_state = tsab_pkg::ST_WR_BYTE;
              next_sda_oe = 1'b0;
            end
          end
        end
        tsab_pkg::ST_WR_BYTE: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_state = tsab_pkg::ST_WR_ACK;
            next_sda_oe = 1'b1;
            wr_strobe = 1'b1;
          end
        end
        tsab_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            next_state = tsab_pkg::ST_WR_BYTE;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
            next_byte_idx = (byte_idx == 2'h3) ? byte_idx : byte_idx + 2'h1;
          end
        end
        tsab_pkg::ST_RD_BYTE: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (is_ara && !sda_oe && !sda_s) begin
              next_state = tsab_pkg::ST_IDLE;
            end
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              next_state = tsab_pkg::ST_RD_ACK;
              next_sda_oe = 1'b0;
              ara_done = is_ara;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_sda_oe = ~tx[6];
            end
          end
        end
        tsab_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            next_rd_more = ~sda_s;
          end else if (scl_fall) begin
            next_state = tsab_pkg::ST_IDLE;
            if (rd_more) begin
              next_state = tsab_pkg::ST_RD_BYTE;
              next_bit_cnt = 4'h0;
              next_byte_idx = 2'h1;
              next_tx = is_ara ? ara_byte : later_byte;
              next_sda_oe = is_ara ? ~ara_byte[7] : ~later_byte[7];
            end
          end
        end
        default: next_state = tsab_pkg::ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Serial engine registers
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= tsab_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      byte_idx <= 2'h0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      rw <= 1'b0;
      is_ara <= 1'b0;
      rd_more <= 1'b0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      tx <= next_tx;
      byte_idx <= next_byte_idx;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
      rw <= next_rw;
      is_ara <= next_is_ara;
      rd_more <= next_rd_more;
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // --------------------------------------------------------------
  // Data line idle timer
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 32'h0;
    end else if (state == tsab_pkg::ST_IDLE || sda_s != sda_prev) begin
      idle_cnt <= 32'h0;
    end else begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // --------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pointer <= tsab_pkg::POINTER_RESET;
      config_value <= tsab_pkg::CONFIG_RESET;
      hysteresis_limit <= tsab_pkg::HYSTERESIS_RESET;
      overtemp_limit <= tsab_pkg::OVERTEMP_RESET;
      stash <= 8'h00;
    end else if (wr_strobe) begin
      if (byte_idx == 2'h0) begin
        pointer <= shift[1:0];
      end else if (byte_idx == 2'h1 && pointer == tsab_pkg::PTR_CONFIG) begin
        config_value <= shift;
      end else if (byte_idx == 2'h1 && is_limit_ptr) begin
        stash <= shift;
      end else if (byte_idx == 2'h2 && pointer == tsab_pkg::PTR_HYSTERESIS) begin
        hysteresis_limit <= {stash, shift};
      end else if (byte_idx == 2'h2 && pointer == tsab_pkg::PTR_OVERTEMP) begin
        overtemp_limit <= {stash, shift};
      end
    end
  end

  // --------------------------------------------------------------
  // Overtemperature indicator
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overtemp_indicator <= 1'b0;
      armed_high <= 1'b1;
      limit_flag <= 1'b0;
      prev_int_mode <= 1'b0;
      prev_shutdown <= 1'b0;
    end else begin
      prev_int_mode <= int_mode;
      prev_shutdown <= shutdown;
      if (int_mode != prev_int_mode) begin
        overtemp_indicator <= 1'b0;
        armed_high <= 1'b1;
      end else if (!int_mode) begin
        if (!shutdown && above) begin
          overtemp_indicator <= 1'b1;
        end else if (!shutdown && below) begin
          overtemp_indicator <= 1'b0;
        end
      end else if (int_set) begin
        overtemp_indicator <= 1'b1;
        armed_high <= ~armed_high;
        limit_flag <= armed_high;
      end else if (int_clear) begin
        overtemp_indicator <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Open-drain output pin
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overtemp_alert_output_out <= 1'b0;
      overtemp_alert_output_oe <= 1'b0;
    end else begin
      overtemp_alert_output_out <= 1'b0;
      overtemp_alert_output_oe <= ~pin_level;
    end
  end

endmodule

/* File: tb/tsab_top_asserts.sv */
`timescale 1ns/1ps
module tsab_top_asserts #(
  parameter int TIMEOUT_CYCLES = tsab_pkg::TIMEOUT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [15:0] temperature,
  input wire logic overtemp_alert_output_out,
  input wire logic overtemp_alert_output_oe,
  input wire logic overtemp_indicator,
  input wire logic [7:0] config_value,
  input wire logic [15:0] hysteresis_limit,
  input wire logic [15:0] overtemp_limit
);
  // ----
  // Helpers
  // ----
  logic [31:0] hold_cnt;
  logic comp_run;
  assign comp_run = !config_value[0] && !config_value[1];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_cnt <= 32'h0;
    end else begin
      hold_cnt <= sda_oe ? hold_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence comp_shutdown_s;
    (config_value[0] && !config_value[1]) [*3];
  endsequence
  sequence int_shutdown_entry_s;
    config_value[1] && $rose(config_value[0]);
  endsequence
  // ----
  // Checks
  // ----
  AST_RESET_STATE: assert property (disable iff (1'b0) rst ##1 rst |-> config_value == 8'h00
    && !overtemp_indicator && hysteresis_limit == 16'h4B00 && overtemp_limit == 16'h5000 && !sda_oe)
    else $error("reset state wrong");
  AST_DATA_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  AST_ALERT_OPEN_DRAIN: assert property (overtemp_alert_output_out == 1'b0)
    else $error("alert drive value not low");
  AST_POLARITY: assert property (overtemp_alert_output_oe == ($past(overtemp_indicator) ^ $past(config_value[2])))
    else $error("alert level does not follow polarity");
  AST_COMP_SET: assert property (comp_run && $signed(temperature) > $signed(overtemp_limit) |-> ##[1:2] overtemp_indicator)
    else $error("indicator not set above limit");
  AST_COMP_CLEAR: assert property (comp_run && $signed(temperature) < $signed(hysteresis_limit) |-> ##[1:2] !overtemp_indicator)
    else $error("indicator not cleared below hysteresis");
  AST_COMP_SHUTDOWN_HOLD: assert property (comp_shutdown_s |-> $stable(overtemp_indicator))
    else $error("indicator moved in comparator shutdown");
  AST_INT_SHUTDOWN_CLEAR: assert property (int_shutdown_entry_s |-> ##2 !overtemp_indicator [*4])
    else $error("interrupt shutdown did not clear");
  AST_BUS_TIMEOUT: assert property (hold_cnt <= TIMEOUT_CYCLES + 8)
    else $error("data line held past timeout");
endmodule

/* File: tb/tsab_master.sv */
`timescale 1ns/1ps
module tsab_master (
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ----
  // Bit timing, 125 ns per bit
  // ----
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic bit_cycle(input logic b, output logic s);
    #20 sda_pull = ~b;
    #42.5 scl = 1'b1;
    #30 s = sda_line;
    #32.5 scl = 1'b0;
  endtask
  // New frame for every register access
  task automatic start();
    if (!scl) begin
      #20 sda_pull = 1'b0;
      #42.5 scl = 1'b1;
    end
    #60 sda_pull = 1'b1;
    #60 scl = 1'b0;
  endtask
  task automatic stop();
    #20 sda_pull = 1'b1;
    #42.5 scl = 1'b1;
    #60 sda_pull = 1'b0;
    #60;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(last, s);
  endtask
endmodule

/* File: tb/tsab_top_bench.sv */
`timescale 1ns/1ps
module tsab_top_bench;
  localparam int TOUT = 200;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] temperature = 16'h1230;
  logic [2:0] pins = 3'h5;
  logic scl, sda_pull, sda_line, sda_out, sda_oe, alert_out, alert_oe, ind;
  logic [7:0] cfg;
  logic [15:0] hyst, otl, v;
  logic [6:0] own;
  int failures = 0;
  int checked = 0;
  assign own = {tsab_pkg::ADDR_UPPER, pins};
  assign sda_line = ~(sda_pull | sda_oe);
  always #5 sys_clk = ~sys_clk;
  tsab_top #(.TIMEOUT_CYCLES(TOUT)) u_tsab_top (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin_2(pins[2]), .address_select_pin_1(pins[1]),
    .address_select_pin_0(pins[0]), .temperature(temperature), .overtemp_alert_output_out(alert_out),
    .overtemp_alert_output_oe(alert_oe), .overtemp_indicator(ind), .config_value(cfg),
    .hysteresis_limit(hyst), .overtemp_limit(otl));
  tsab_master u_tsab_master (.sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
  // ----
  // Helpers
  // ----
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] p, input int n, input logic [23:0] d);
    logic a;
    u_tsab_master.start();
    u_tsab_master.put_byte({own, 1'b0}, a);
    check("address ack", 16'(a), 16'h1);
    u_tsab_master.put_byte(p, a);
    for (int i = 0; i < n; i++) begin
      u_tsab_master.put_byte(d[23-8*i -: 8], a);
    end
    u_tsab_master.stop();
  endtask
  task automatic rd(input int n, output logic [15:0] r);
    logic a;
    logic [7:0] b;
    r = 16'h0;
    u_tsab_master.start();
    u_tsab_master.put_byte({own, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      u_tsab_master.get_byte(i == n - 1, b);
      r = {r[7:0], b};
    end
    u_tsab_master.stop();
  endtask
  task automatic ara(input logic exp_ack, input logic [7:0] exp_byte);
    logic a;
    logic [7:0] b;
    u_tsab_master.start();
    u_tsab_master.put_byte({tsab_pkg::ALERT_RESPONSE_ADDR, 1'b1}, a);
    check("response ack", 16'(a), 16'(exp_ack));
    if (a === 1'b1) begin
      u_tsab_master.get_byte(1'b1, b);
      check("response byte", 16'(b), 16'(exp_byte));
    end
    u_tsab_master.stop();
  endtask
  task automatic ara_rival(input logic [7:0] rv);
    logic a;
    logic s;
    logic [7:0] b;
    u_tsab_master.start();
    u_tsab_master.put_byte({tsab_pkg::ALERT_RESPONSE_ADDR, 1'b1}, a);
    check("rival ack", 16'(a), 16'h1);
    for (int i = 7; i >= 0; i--) begin
      u_tsab_master.bit_cycle(rv[i], s);
      b[i] = s;
    end
    u_tsab_master.bit_cycle(1'b1, s);
    check("rival response", 16'(b), 16'(rv));
    u_tsab_master.stop();
  endtask
  task automatic cfgw(input logic [7:0] c);
    wr(8'(tsab_pkg::PTR_CONFIG), 1, {c, 16'h0000});
  endtask
  task automatic temp(input logic [15:0] t);
    @(posedge sys_clk);
    #1 temperature = t;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    check("config reset", 16'(cfg), 16'h0000);
    rd(2, v);
    check("temperature read", v, 16'h1230);
    wr(8'(tsab_pkg::PTR_OVERTEMP), 3, 24'h6400A5);
    check("overtemp limit", otl, 16'h6400);
    wr(8'(tsab_pkg::PTR_HYSTERESIS), 2, 24'h5A0000);
    check("hysteresis limit", hyst, 16'h5A00);
    wr(8'(tsab_pkg::PTR_CONFIG), 2, 24'h04FF00);
    check("config surplus", 16'(cfg), 16'h0004);
    wr(8'(tsab_pkg::PTR_OVERTEMP), 0, 24'h0);
    check("pointer only", otl, 16'h6400);
    rd(2, v);
    check("limit read", v, 16'h6400);
    rd(2, v);
    check("limit reread", v, 16'h6400);
    $display("test regs done");
  endtask
  task automatic t_comp();
    cfgw(8'h00);
    temp(16'h6500);
    check("comparator set", 16'(ind), 16'h1);
    check("alert pulls low", 16'(alert_oe), 16'h1);
    temp(16'h6000);
    check("hysteresis band", 16'(ind), 16'h1);
    temp(16'h5900);
    check("comparator clear", 16'(ind), 16'h0);
    temp(16'h6500);
    cfgw(8'h01);
    check("shutdown holds", 16'(ind), 16'h1);
    cfgw(8'h04);
    temp(16'h5900);
    check("active high idle", 16'(alert_oe), 16'h1);
    $display("test comp done");
  endtask
  task automatic t_int();
    cfgw(8'h02);
    temp(16'h6500);
    check("interrupt set", 16'(ind), 16'h1);
    rd(1, v);
    check("config read", v, 16'h0002);
    check("read clears", 16'(ind), 16'h0);
    temp(16'h6600);
    check("no repeat high", 16'(ind), 16'h0);
    temp(16'h5900);
    check("low event", 16'(ind), 16'h1);
    rd(1, v);
    check("read clears low", 16'(ind), 16'h0);
    temp(16'h6500);
    check("high event", 16'(ind), 16'h1);
    cfgw(8'h03);
    check("shutdown clears", 16'(ind), 16'h0);
    $display("test int done");
  endtask
  task automatic t_alert();
    temp(16'h5900);
    cfgw(8'h00);
    cfgw(8'h82);
    temp(16'h6500);
    ara_rival(8'h95);
    check("alert kept", 16'(ind), 16'h1);
    ara(1'b1, {own, 1'b1});
    check("response clears", 16'(ind), 16'h0);
    ara(1'b0, 8'h00);
    temp(16'h5900);
    ara(1'b1, {own, 1'b0});
    cfgw(8'h02);
    temp(16'h6500);
    check("pending alert", 16'(ind), 16'h1);
    ara(1'b0, 8'h00);
    $display("test alert done");
  endtask
  task automatic t_tout();
    logic a;
    cfgw(8'h00);
    u_tsab_master.start();
    u_tsab_master.put_byte({own ^ 7'h01, 1'b0}, a);
    check("foreign address", 16'(a), 16'h0);
    u_tsab_master.stop();
    wr(8'(tsab_pkg::PTR_OVERTEMP), 0, 24'h0);
    u_tsab_master.start();
    u_tsab_master.put_byte({own, 1'b1}, a);
    repeat (20) @(posedge sys_clk);
    #1 check("drives data", 16'(sda_oe), 16'h1);
    repeat (TOUT + 20) @(posedge sys_clk);
    #1 check("timeout release", 16'(sda_oe), 16'h0);
    u_tsab_master.stop();
    rd(2, v);
    check("after timeout", v, 16'h6400);
    $display("test timeout done");
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_comp();
    t_int();
    t_alert();
    t_tout();
    results();
  end
  initial begin
    #600000;
    failures++;
    results();
  end
endmodule
bind tsab_top tsab_top_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_tsab_top_asserts (.sys_clk(sys_clk), .rst(rst),
  .sda_out(sda_out), .sda_oe(sda_oe), .temperature(temperature),
  .overtemp_alert_output_out(overtemp_alert_output_out), .overtemp_alert_output_oe(overtemp_alert_output_oe),
  .overtemp_indicator(overtemp_indicator), .config_value(config_value), .hysteresis_limit(hysteresis_limit),
  .overtemp_limit(overtemp_limit));
